// *** lfast_pkg.sv ***
package lfast_pkg;
    localparam int LANES = 16;
    localparam int TRIMS = 5;
    // printed offsets are not all word multiples: they are indices, byte address is 4x
    localparam logic [9:0] IDX_ALARM_STATUS_REG = 10'h2c1;
    localparam logic [9:0] IDX_LANE_ALM   = 10'h2c4;
    localparam logic [9:0] IDX_IRQ_MASK   = 10'h2c8;
    localparam logic [9:0] IDX_TRIM_A_DUAL = 10'h310;
    localparam logic [9:0] IDX_TRIM_B_DUAL = 10'h313;
    localparam logic [9:0] IDX_TRIM_A_SIA  = 10'h314;
    localparam logic [9:0] IDX_TRIM_B_SIA  = 10'h315;
    localparam logic [9:0] IDX_TRIM_A_SIB  = 10'h31a;
    localparam int SUMMARY_BIT = 5;
    localparam logic [15:0] LANE_ALM_RESET = 16'hffff;
    localparam logic [7:0]  IRQ_MASK_RESET = 8'h00;
    localparam logic [2:0]  TRIM_A_DUAL = 3'd0;
    localparam logic [2:0]  TRIM_B_DUAL = 3'd1;
    localparam logic [2:0]  TRIM_A_SIA  = 3'd2;
    localparam logic [2:0]  TRIM_B_SIA  = 3'd3;
    localparam logic [2:0]  TRIM_A_SIB  = 3'd4;
    typedef struct packed {
        logic [7:0] core_a;
        logic [7:0] core_b;
    } lfast_trim_out_t;
    typedef enum logic [1:0] {
        LFAST_IDLE   = 2'b00,
        LFAST_ACCESS = 2'b01
    } lfast_state_t;
endpackage

// *** lfast_regs.sv ***
`timescale 1ns/1ps
module lfast_regs
    import lfast_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic [LANES-1:0]    lane_fifo_fault,
    input  wire logic [LANES-1:0]    lane_active,
    input  wire logic                dual_channel_mode,
    input  wire logic                sample_input_b,
    input  wire logic                fuse_valid,
    input  wire logic [8*TRIMS-1:0]  fuse_trim,
    output lfast_trim_out_t          trim_out,
    output logic                     irq
);
    function automatic logic [2:0] trim_index(input logic [9:0] idx);
        case (idx)
            IDX_TRIM_A_DUAL: trim_index = TRIM_A_DUAL;
            IDX_TRIM_B_DUAL: trim_index = TRIM_B_DUAL;
            IDX_TRIM_A_SIA:  trim_index = TRIM_A_SIA;
            IDX_TRIM_B_SIA:  trim_index = TRIM_B_SIA;
            IDX_TRIM_A_SIB:  trim_index = TRIM_A_SIB;
            default:         trim_index = 3'd7;
        endcase
    endfunction

    lfast_state_t       state_q, state_d;
    logic [LANES-1:0]   lane_alm_q, lane_alm_d;
    logic               summary_q, summary_d;
    logic [7:0]         mask_q, mask_d;
    logic [7:0]         trim_q [TRIMS];
    logic [7:0]         trim_d [TRIMS];
    logic               fuse_done_q, fuse_done_d;
    logic [31:0]        prdata_d;
    logic               pslverr_d, pready_d, irq_d;
    lfast_trim_out_t    trim_out_d;
    logic [9:0]         idx;
    logic               wr, hit;
    logic [2:0]         ti;
    logic [LANES-1:0]   active_fault;

    assign idx = paddr[11:2];
    assign ti  = trim_index(idx);

    always_comb begin
        state_d      = state_q;
        lane_alm_d   = lane_alm_q;
        summary_d    = summary_q;
        mask_d       = mask_q;
        trim_d       = trim_q;
        fuse_done_d  = fuse_done_q;
        prdata_d     = 32'h0000_0000;
        pslverr_d    = 1'b0;
        pready_d     = 1'b0;
        wr           = 1'b0;
        hit          = (idx == IDX_ALARM_STATUS_REG) || (idx == IDX_LANE_ALM) ||
                       (idx == IDX_IRQ_MASK) || (ti != 3'd7);
        active_fault = lane_fifo_fault & lane_active;
        // one wait state: access is answered the cycle after penable rises
        case (state_q)
            LFAST_IDLE: begin
                if (psel && penable) begin
                    state_d  = LFAST_ACCESS;
                    pready_d = 1'b1;
                end
            end
            LFAST_ACCESS: begin
                state_d = LFAST_IDLE;
                wr = psel && penable && pwrite;
            end
            default: state_d = LFAST_IDLE;
        endcase
        if (!fuse_done_q && fuse_valid) begin
            for (int i = 0; i < TRIMS; i++) begin
                trim_d[i] = fuse_trim[8*i +: 8];
            end
            fuse_done_d = 1'b1;
        end
        if (wr && pstrb[0] && idx == IDX_LANE_ALM) begin
            lane_alm_d[7:0] = lane_alm_d[7:0] & ~pwdata[7:0];
        end
        if (wr && pstrb[1] && idx == IDX_LANE_ALM) begin
            lane_alm_d[15:8] = lane_alm_d[15:8] & ~pwdata[15:8];
        end
        if (wr && pstrb[0] && idx == IDX_ALARM_STATUS_REG && pwdata[SUMMARY_BIT]) begin
            summary_d  = 1'b0;
            lane_alm_d = '0;
        end
        if (wr && pstrb[0] && idx == IDX_IRQ_MASK) begin
            mask_d = pwdata[7:0];
        end
        if (wr && pstrb[0] && ti != 3'd7) begin
            trim_d[ti] = pwdata[7:0];
        end
        lane_alm_d = lane_alm_d | lane_fifo_fault;
        if (|active_fault) begin
            summary_d = 1'b1;
        end
        if (psel && penable && !pwrite && state_q == LFAST_IDLE) begin
            case (idx)
                IDX_ALARM_STATUS_REG: prdata_d[SUMMARY_BIT] = summary_q;
                IDX_LANE_ALM:   prdata_d[15:0] = lane_alm_q;
                IDX_IRQ_MASK:   prdata_d[7:0] = mask_q;
                default: begin
                    if (ti != 3'd7) begin
                        prdata_d[7:0] = trim_q[ti];
                    end
                end
            endcase
        end
        if (psel && penable && state_q == LFAST_IDLE && !hit) begin
            pslverr_d = 1'b1;
        end
        if (dual_channel_mode) begin
            trim_out_d.core_a = trim_q[TRIM_A_DUAL];
            trim_out_d.core_b = trim_q[TRIM_B_DUAL];
        end else if (!sample_input_b) begin
            trim_out_d.core_a = trim_q[TRIM_A_SIA];
            trim_out_d.core_b = trim_q[TRIM_B_SIA];
        end else begin
            // single input b; core b trim lies outside this segment
            trim_out_d.core_a = trim_q[TRIM_A_SIB];
            trim_out_d.core_b = 8'h00;
        end
        // mask bit set enables: mask bits 0..7 gate lane bits 0..7, mask bit 5 also gates summary
        irq_d = |(lane_alm_q[7:0] & mask_q[7:0]) | (summary_q & mask_q[SUMMARY_BIT]);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= LFAST_IDLE;
            lane_alm_q  <= LANE_ALM_RESET;
            summary_q   <= 1'b1;
            mask_q      <= IRQ_MASK_RESET;
            fuse_done_q <= 1'b0;
            for (int i = 0; i < TRIMS; i++) begin
                trim_q[i] <= 8'h00;
            end
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
            pready      <= 1'b0;
            trim_out    <= '0;
            irq         <= 1'b0;
        end else begin
            state_q     <= state_d;
            lane_alm_q  <= lane_alm_d;
            summary_q   <= summary_d;
            mask_q      <= mask_d;
            fuse_done_q <= fuse_done_d;
            trim_q      <= trim_d;
            prdata      <= prdata_d;
            pslverr     <= pslverr_d;
            pready      <= pready_d;
            trim_out    <= trim_out_d;
            irq         <= irq_d;
        end
    end
endmodule

// *** lfast_regs_checker.sv ***
`timescale 1ns/1ps
module lfast_regs_checker
    import lfast_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic [LANES-1:0] lane_fifo_fault,
    input wire logic             dual_channel_mode,
    input wire logic             sample_input_b,
    input wire logic             fuse_valid,
    input wire lfast_trim_out_t  trim_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // three quiet cycles: a load lands in trim_out one cycle late
    sequence s_quiet;
        !psel && $stable(fuse_valid) && $stable({dual_channel_mode, sample_input_b});
    endsequence
    a_ready_one_wait: assert property (s_access |=> pready ##1 !pready)
        else $error("late pready");
    a_ready_has_req: assert property (pready |-> $past(psel && penable))
        else $error("stray pready");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("bad error answer");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("data without pready");
    a_trim_no_err: assert property (
        pready && paddr == {IDX_TRIM_A_DUAL, 2'b00} |-> !pslverr)
        else $error("error on trim");
    a_fault_reads_set: assert property (
        pready && !pwrite && paddr == {IDX_LANE_ALM, 2'b00}
        |-> &(prdata[15:0] | ~($past(lane_fifo_fault, 2) & $past(lane_fifo_fault, 3))))
        else $error("held fault reads clear");
    a_trim_holds: assert property (s_quiet [*3] |-> $stable(trim_out))
        else $error("trim moved");
    a_input_b_core_b: assert property (
        $past(!dual_channel_mode && sample_input_b) |-> trim_out.core_b == 8'h00)
        else $error("core b trim in input b");
endmodule
bind lfast_regs lfast_regs_checker lfast_regs_checker_i (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pready, .prdata, .pslverr, .lane_fifo_fault, .dual_channel_mode,
    .sample_input_b, .fuse_valid, .trim_out);

// *** lfast_regs_tb_top.sv ***
`timescale 1ns/1ps
module lfast_regs_tb_top import lfast_pkg::*;;
    logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        dual_channel_mode = 1, sample_input_b = 0, fuse_valid = 0;
    logic        pready, pslverr, irq, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] lane_fifo_fault = 0, lane_active = 0;
    logic [39:0] fuse_trim = 40'h5a_4b3c_2d1e;
    logic [9:0]  tix [5] = '{IDX_TRIM_A_DUAL, IDX_TRIM_B_DUAL, IDX_TRIM_A_SIA,
                            IDX_TRIM_B_SIA, IDX_TRIM_A_SIB};
    lfast_trim_out_t trim_out;
    int          n_fail = 0, comparisons = 0;
    lfast_regs lfast_regs_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .pready, .prdata, .pslverr, .lane_fifo_fault, .lane_active,
        .dual_channel_mode, .sample_input_b, .fuse_valid, .fuse_trim, .trim_out, .irq);
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // extra edge at the end so a following call never re-drives psel in the same step
    task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [9:0] ix, input logic [31:0] exp, input string nm);
        apb(1'b0, ix, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        fuse_valid <= 1'b1;
        rdc(IDX_LANE_ALM, 32'h0000_ffff, "lanes");
        apb(1'b1, IDX_LANE_ALM, 32'h0000_00ff);
        rdc(IDX_LANE_ALM, 32'h0000_ff00, "lanes");
        apb(1'b1, IDX_ALARM_STATUS_REG, 32'h0000_0020);
        rdc(IDX_LANE_ALM, 32'h0000_0000, "lanes");
        rdc(IDX_ALARM_STATUS_REG, 32'h0000_0000, "summary");
        lane_fifo_fault <= 16'h0208;
        lane_active <= 16'h0008;
        @(posedge ref_clk);
        lane_fifo_fault <= 16'h0008;
        rdc(IDX_LANE_ALM, 32'h0000_0208, "lanes");
        rdc(IDX_ALARM_STATUS_REG, 32'h0000_0020, "summary");
        apb(1'b1, IDX_LANE_ALM, 32'h0000_0208);
        rdc(IDX_LANE_ALM, 32'h0000_0008, "lanes");
        apb(1'b1, IDX_IRQ_MASK, 32'h0000_0008);
        // irq is registered one edge after the mask lands
        @(posedge ref_clk);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, IDX_IRQ_MASK, 32'h0000_0000);
        @(posedge ref_clk);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, IDX_IRQ_MASK, 32'h0000_0008);
        lane_fifo_fault <= 16'h0000;
        apb(1'b1, IDX_LANE_ALM, 32'h0000_0008);
        @(posedge ref_clk);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        apb(1'b0, 10'h300, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        for (int i = 0; i < TRIMS; i++) begin
            rdc(tix[i], {24'h0, fuse_trim[8*i+:8]}, "fuse");
            apb(1'b1, tix[i], 32'h0000_0090 + i);
            rdc(tix[i], 32'h0000_0090 + i, "trim");
        end
        for (int i = 0; i < 3; i++) begin
            dual_channel_mode <= (i == 0);
            sample_input_b <= (i == 2);
            repeat (3) @(posedge ref_clk);
            rd = {8'h90 + 8'(2 * i), (i == 2) ? 8'h00 : 8'h91 + 8'(2 * i)};
            chk("trim_out", rd, {16'h0000, trim_out});
        end
        test_done();
    end
endmodule
